// ==== common/adc_timing_pkg.sv ====
// constants and types shared by the conversion timing controller
package adc_timing_pkg;

  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned RESULT_W      = 10;
  localparam int unsigned CHAN_W        = 3;
  localparam int unsigned CODE_W        = 3;
  localparam int unsigned CNT_W         = 9;
  localparam int unsigned SYNC_W        = 3;
  localparam int unsigned WAIT_CYCLES   = 2;

  // reference settling time in microseconds, and its cycle counts
  localparam int unsigned REF_SETTLE_US     = 17;
  localparam int unsigned REF_SETTLE_HI_US  = 14;
  localparam int unsigned REF_SETTLE_CYC    = REF_SETTLE_US * CLK_MHZ;
  localparam int unsigned REF_SETTLE_HI_CYC = REF_SETTLE_HI_US * CLK_MHZ;
  localparam int unsigned SETTLE_W          = 11;

  localparam logic [CODE_W-1:0] CODE_288 = 3'h0;
  localparam logic [CODE_W-1:0] CODE_240 = 3'h1;
  localparam logic [CODE_W-1:0] CODE_192 = 3'h2;
  localparam logic [CODE_W-1:0] CODE_144 = 3'h4;
  localparam logic [CODE_W-1:0] CODE_120 = 3'h5;
  localparam logic [CODE_W-1:0] CODE_96  = 3'h6;

  localparam logic [CNT_W-1:0] CONV_288 = 9'h120;
  localparam logic [CNT_W-1:0] CONV_240 = 9'h0F0;
  localparam logic [CNT_W-1:0] CONV_192 = 9'h0C0;
  localparam logic [CNT_W-1:0] CONV_144 = 9'h090;
  localparam logic [CNT_W-1:0] CONV_120 = 9'h078;
  localparam logic [CNT_W-1:0] CONV_96  = 9'h060;

  localparam logic [CNT_W-1:0] SAMP_40 = 9'h028;
  localparam logic [CNT_W-1:0] SAMP_32 = 9'h020;
  localparam logic [CNT_W-1:0] SAMP_24 = 9'h018;
  localparam logic [CNT_W-1:0] SAMP_20 = 9'h014;
  localparam logic [CNT_W-1:0] SAMP_16 = 9'h010;
  localparam logic [CNT_W-1:0] SAMP_12 = 9'h00C;

  // start delay uses the maximum of each documented range
  localparam logic [CNT_W-1:0] DLY_12 = 9'h00C;
  localparam logic [CNT_W-1:0] DLY_11 = 9'h00B;
  localparam logic [CNT_W-1:0] DLY_10 = 9'h00A;

  localparam logic [CNT_W-1:0] CNT_ONE  = 9'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_DELAY = 2'b10,
    ST_CONV  = 2'b11
  } conv_state_t;

endpackage

// ==== rtl/conv_time_decode.sv ====
// decode of the conversion-time select code into cycle counts
`timescale 1ns/1ns
module conv_time_decode
  import adc_timing_pkg::*;
(
  input  wire logic [CODE_W-1:0] i_code,
  output logic      [CNT_W-1:0]  o_conv_len,
  output logic      [CNT_W-1:0]  o_samp_len,
  output logic      [CNT_W-1:0]  o_delay_len,
  output logic                   o_code_bad
);

  always_comb
  begin
    o_conv_len  = CONV_288;
    o_samp_len  = SAMP_40;
    o_delay_len = DLY_12;
    o_code_bad  = 1'b0;
    unique case (i_code)
      CODE_288:
      begin
        o_conv_len  = CONV_288;
        o_samp_len  = SAMP_40;
        o_delay_len = DLY_12;
      end
      CODE_240:
      begin
        o_conv_len  = CONV_240;
        o_samp_len  = SAMP_32;
        o_delay_len = DLY_12;
      end
      CODE_192:
      begin
        o_conv_len  = CONV_192;
        o_samp_len  = SAMP_24;
        o_delay_len = DLY_11;
      end
      CODE_144:
      begin
        o_conv_len  = CONV_144;
        o_samp_len  = SAMP_20;
        o_delay_len = DLY_10;
      end
      CODE_120:
      begin
        o_conv_len  = CONV_120;
        o_samp_len  = SAMP_16;
        o_delay_len = DLY_10;
      end
      CODE_96:
      begin
        o_conv_len  = CONV_96;
        o_samp_len  = SAMP_12;
        o_delay_len = DLY_12;
      end
      default:
      begin
        // prohibited codes: converter refuses to start
        o_code_bad = 1'b1;
      end
    endcase
  end

endmodule

// ==== rtl/adc_conversion_timing_control.sv ====
// conversion sequencer: start delay, sampling, conversion, result latch
`timescale 1ns/1ns

// Functional notes
// - select code sets conversion and sampling cycle counts; other codes prohibited
// - a code-dependent start delay precedes sampling after conversion is enabled
// - start delay counts only after the enabling access's bus wait has ended
// - sampling is inside the conversion time; end falls conversion-count after sampling
// - mode or channel writes may spoil result; software reads result first
// - run set early after reference-on, or reference off: first result flagged
// - result is a 10-bit binary code, one step is reference over 1024
// - run starts conversion; each result with SAR done and without a coinciding mode or channel write is stored and next conversion starts
// - clearing run mid-conversion aborts with no result stored
// - compare off: done request raised at the end of every conversion without a coinciding mode or channel write
module adc_conversion_timing_control
  import adc_timing_pkg::*;
#(
  parameter int unsigned SETTLE_CYC    = REF_SETTLE_CYC,
  parameter int unsigned SETTLE_HI_CYC = REF_SETTLE_HI_CYC
)
(
  input  wire logic                i_core_clk,
  input  wire logic                i_resetn,
  input  wire logic                i_clk_en,
  input  wire logic                i_conversion_run,
  input  wire logic                i_reference_on,
  input  wire logic                i_ref_high,
  input  wire logic [CODE_W-1:0]   i_conversion_time_select,
  input  wire logic [CHAN_W-1:0]   i_channel_select,
  input  wire logic                i_mode_write,
  input  wire logic                i_channel_write,
  input  wire logic                i_compare_enable,
  input  wire logic                i_compare_below,
  input  wire logic [RESULT_W-1:0] i_compare_threshold,
  input  wire logic                i_sar_done,
  input  wire logic [RESULT_W-1:0] i_sar_value,
  output logic                     o_sample,
  output logic                     o_sar_start,
  output logic [CHAN_W-1:0]        o_channel,
  output logic [RESULT_W-1:0]      o_conversion_result,
  output logic                     o_result_valid,
  output logic                     o_result_suspect,
  output logic                     o_conversion_done_irq,
  output logic                     o_end_strobe,
  output logic                     o_busy,
  output logic                     o_code_bad
);

  // ****************************************************************
  // reset release and state
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  typedef struct packed {
    conv_state_t             st;
    logic [CNT_W-1:0]        cnt;
    logic [CNT_W-1:0]        samp;
    logic [SETTLE_W-1:0]     settle;
    logic                    ref_q;
    logic                    first_bad;
    logic                    sample;
    logic                    sar_start;
    logic [CHAN_W-1:0]       chan;
    logic [RESULT_W-1:0]     result;
    logic                    valid;
    logic                    suspect;
    logic                    irq;
    logic                    strobe;
    logic                    code_bad;
    logic                    busy;
  } ctrl_t;

  ctrl_t s_q;
  ctrl_t s_d;

  logic [CNT_W-1:0] conv_len;
  logic [CNT_W-1:0] samp_len;
  logic [CNT_W-1:0] delay_len;
  logic             bad_code;

  conv_time_decode u_decode (
    .i_code      (i_conversion_time_select),
    .o_conv_len  (conv_len),
    .o_samp_len  (samp_len),
    .o_delay_len (delay_len),
    .o_code_bad  (bad_code)
  );

  // ****************************************************************
  // sequencing
  // ****************************************************************
  logic             reg_write;
  logic             cmp_hit;
  logic [SETTLE_W-1:0] settle_need;

  always_comb
  begin
    reg_write   = i_mode_write | i_channel_write;
    settle_need = i_ref_high ? SETTLE_W'(SETTLE_HI_CYC) : SETTLE_W'(SETTLE_CYC);
    cmp_hit     = i_compare_below ? (i_sar_value <  i_compare_threshold)
                                  : (i_sar_value >= i_compare_threshold);
    s_d           = s_q;
    s_d.sar_start = 1'b0;
    s_d.strobe    = 1'b0;
    s_d.irq       = 1'b0;
    s_d.code_bad  = bad_code;
    s_d.ref_q     = i_reference_on;
    // reference settling counter restarts on reference-on rising
    if (!i_reference_on)
      s_d.settle = '0;
    else if (!s_q.ref_q)
      s_d.settle = '0;
    else if (s_q.settle != settle_need && s_q.settle != {SETTLE_W{1'b1}})
      s_d.settle = s_q.settle + SETTLE_W'(1);
    // a mode or channel write may leave the result unusable
    if (reg_write)
      s_d.valid = 1'b0;
    unique case (s_q.st)
      ST_IDLE:
      begin
        s_d.sample = 1'b0;
        if (i_conversion_run && !bad_code)
        begin
          s_d.st        = ST_WAIT;
          s_d.cnt       = CNT_WORD(WAIT_CYCLES);
          s_d.chan      = i_channel_select;
          s_d.first_bad = !i_reference_on || (s_q.settle < settle_need);
        end
      end
      ST_WAIT:
      begin
        // the enabling access still holds its bus wait
        if (!i_conversion_run)
          s_d.st = ST_IDLE;
        else if (s_q.cnt == CNT_ONE)
        begin
          s_d.st  = ST_DELAY;
          s_d.cnt = delay_len;
        end
        else
          s_d.cnt = s_q.cnt - CNT_ONE;
      end
      ST_DELAY:
      begin
        if (!i_conversion_run)
          s_d.st = ST_IDLE;
        else if (s_q.cnt == CNT_ONE)
        begin
          s_d.st        = ST_CONV;
          s_d.cnt       = conv_len;
          s_d.samp      = samp_len;
          s_d.sample    = 1'b1;
          s_d.sar_start = 1'b1;
        end
        else
          s_d.cnt = s_q.cnt - CNT_ONE;
      end
      ST_CONV:
      begin
        if (!i_conversion_run)
        begin
          s_d.st     = ST_IDLE;
          s_d.sample = 1'b0;
        end
        else
        begin
          // sampling window runs inside the conversion count
          if (s_q.samp == CNT_ONE)
            s_d.sample = 1'b0;
          if (s_q.samp != CNT_ZERO)
            s_d.samp = s_q.samp - CNT_ONE;
          if (s_q.cnt == CNT_ONE)
          begin
            s_d.strobe = 1'b1;
            // a coinciding mode or channel write wins: no store, no request
            if (!reg_write)
            begin
              s_d.result  = i_sar_done ? i_sar_value : s_q.result;
              s_d.valid   = 1'b1;
              s_d.suspect = s_q.first_bad;
              s_d.irq     = !i_compare_enable || cmp_hit;
            end
            s_d.first_bad = 1'b0;
            // next conversion starts straight away, channel re-read
            s_d.cnt       = conv_len;
            s_d.samp      = samp_len;
            s_d.sample    = 1'b1;
            s_d.sar_start = 1'b1;
            s_d.chan      = i_channel_select;
          end
          else
            s_d.cnt = s_q.cnt - CNT_ONE;
        end
      end
    endcase
    // busy is registered so the output comes straight from a flop
    s_d.busy = (s_d.st != ST_IDLE);
  end

  function automatic logic [CNT_W-1:0] CNT_WORD(input int unsigned n);
    CNT_WORD = CNT_W'(n);
  endfunction

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else if (i_clk_en)
      s_q <= s_d;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_sample              = s_q.sample;
  assign o_sar_start           = s_q.sar_start;
  assign o_channel             = s_q.chan;
  assign o_conversion_result   = s_q.result;
  assign o_result_valid        = s_q.valid;
  assign o_result_suspect      = s_q.suspect;
  assign o_conversion_done_irq = s_q.irq;
  assign o_end_strobe          = s_q.strobe;
  assign o_busy                = s_q.busy;
  assign o_code_bad            = s_q.code_bad;

endmodule

// ==== tb/adc_timing_checker.sv ====
// port checker for the conversion timing controller
`timescale 1ns/1ns
module adc_timing_checker
  import adc_timing_pkg::*;
(
  input wire logic                i_core_clk,
  input wire logic                i_resetn,
  input wire logic                i_conversion_run,
  input wire logic [CODE_W-1:0]   i_conversion_time_select,
  input wire logic                i_mode_write,
  input wire logic                i_channel_write,
  input wire logic                i_compare_enable,
  input wire logic                i_sar_done,
  input wire logic [RESULT_W-1:0] i_sar_value,
  input wire logic                o_sample,
  input wire logic                o_sar_start,
  input wire logic [RESULT_W-1:0] o_conversion_result,
  input wire logic                o_result_valid,
  input wire logic                o_conversion_done_irq,
  input wire logic                o_end_strobe,
  input wire logic                o_busy
);
  localparam logic [CNT_W-1:0] CONV_T [8] = '{CONV_288, CONV_240, CONV_192, CNT_ZERO,
                                              CONV_144, CONV_120, CONV_96, CNT_ZERO};
  localparam logic [CNT_W-1:0] SAMP_T [8] = '{SAMP_40, SAMP_32, SAMP_24, CNT_ZERO,
                                              SAMP_20, SAMP_16, SAMP_12, CNT_ZERO};
  localparam logic [CNT_W-1:0] DLY_T [8]  = '{DLY_12, DLY_12, DLY_11, CNT_ZERO,
                                              DLY_10, DLY_10, DLY_12, CNT_ZERO};
  logic [CNT_W:0] start_cnt_q;
  logic [CNT_W:0] busy_cnt_q;

  // saturating counters: cycles since the last start, and since leaving idle
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      start_cnt_q <= '0;
      busy_cnt_q  <= '0;
    end
    else
    begin
      if (o_sar_start)
        start_cnt_q <= 10'h001;
      else if (~&start_cnt_q)
        start_cnt_q <= start_cnt_q + 10'h001;
      if (!o_busy)
        busy_cnt_q <= '0;
      else if (~&busy_cnt_q)
        busy_cnt_q <= busy_cnt_q + 10'h001;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_write;
    i_mode_write || i_channel_write;
  endsequence
  sequence s_quiet;
    !o_end_strobe && !o_conversion_done_irq;
  endsequence

  property p_end_pulse;
    o_end_strobe |=> !o_end_strobe;
  endproperty
  property p_conv_len;
    o_end_strobe |-> start_cnt_q == {1'b0, CONV_T[i_conversion_time_select]};
  endproperty
  property p_samp_len;
    $fell(o_sample) && o_busy |-> start_cnt_q == {1'b0, SAMP_T[i_conversion_time_select]};
  endproperty
  property p_start_delay;
    o_sar_start && !o_end_strobe |->
      busy_cnt_q == {1'b0, DLY_T[i_conversion_time_select]} + 10'h002;
  endproperty
  property p_restart;
    o_end_strobe |-> o_sar_start;
  endproperty
  property p_stop;
    !i_conversion_run |=> !o_busy ##0 s_quiet;
  endproperty
  property p_irq;
    o_end_strobe && !$past(i_compare_enable) && !$past(i_mode_write)
      && !$past(i_channel_write) |-> o_conversion_done_irq;
  endproperty
  property p_store;
    o_end_strobe && $past(i_sar_done) && !$past(i_mode_write) && !$past(i_channel_write)
      |-> o_result_valid && o_conversion_result == $past(i_sar_value);
  endproperty
  property p_write;
    s_write |=> !o_result_valid && !o_conversion_done_irq;
  endproperty
  property p_bad_code;
    !o_busy && i_conversion_time_select[1:0] == 2'b11 |=> !o_busy;
  endproperty

  a_end_pulse: assert property (p_end_pulse)
    else $error("end strobe wider than one cycle");
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");
  a_samp_len: assert property (p_samp_len)
    else $error("sampling length wrong");
  a_start_delay: assert property (p_start_delay)
    else $error("start delay wrong");
  a_restart: assert property (p_restart)
    else $error("no automatic restart");
  a_stop: assert property (p_stop)
    else $error("run low did not stop");
  a_irq: assert property (p_irq)
    else $error("done request missing");
  a_store: assert property (p_store)
    else $error("result not stored");
  a_write: assert property (p_write)
    else $error("write did not win");
  a_bad_code: assert property (p_bad_code)
    else $error("prohibited code started");
endmodule

// ==== tb/adc_conversion_timing_control_tb.sv ====
// self-checking bench of the conversion timing controller
`timescale 1ns/1ns
module adc_conversion_timing_control_tb;
  import adc_timing_pkg::*;
  logic                i_core_clk, i_resetn, i_clk_en, i_conversion_run, i_reference_on;
  logic                i_ref_high, i_mode_write, i_channel_write, i_compare_enable;
  logic                i_compare_below, i_sar_done;
  logic [CODE_W-1:0]   i_conversion_time_select;
  logic [CHAN_W-1:0]   i_channel_select, o_channel;
  logic [RESULT_W-1:0] i_compare_threshold, i_sar_value, o_conversion_result, last;
  logic                o_sample, o_sar_start, o_result_valid, o_result_suspect;
  logic                o_conversion_done_irq, o_end_strobe, o_busy, o_code_bad;
  logic [31:0]         rng;
  int                  failures, num_checks;
  int                  n_tab [8] = '{288, 240, 192, 0, 144, 120, 96, 0};
  int                  s_tab [8] = '{40, 32, 24, 0, 20, 16, 12, 0};
  int                  d_tab [8] = '{12, 12, 11, 0, 10, 10, 12, 0};

  // short settle counts keep the reference scenarios brief
  adc_conversion_timing_control #(.SETTLE_CYC(20), .SETTLE_HI_CYC(15)) dut (
    .i_core_clk, .i_resetn, .i_clk_en, .i_conversion_run, .i_reference_on, .i_ref_high,
    .i_conversion_time_select, .i_channel_select, .i_mode_write, .i_channel_write,
    .i_compare_enable, .i_compare_below, .i_compare_threshold, .i_sar_done, .i_sar_value,
    .o_sample, .o_sar_start, .o_channel, .o_conversion_result, .o_result_valid,
    .o_result_suspect, .o_conversion_done_irq, .o_end_strobe, .o_busy, .o_code_bad);

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // mode 0 plain, 1 abort in the first conversion, 2 mode write at the last end
  task automatic convs(input int c, input int nconv, input int mode, input logic sus);
    int         k;
    int         hi;
    logic [9:0] v;
    logic [2:0] ch;
    logic [9:0] thr;
    logic       en;
    logic       below;
    rng = xs(rng);
    ch = rng[2:0];
    thr = rng[19:10];
    en = rng[20];
    below = rng[21];
    @(posedge i_core_clk);
    i_conversion_time_select <= 3'(c);
    i_channel_select <= ch;
    i_compare_threshold <= thr;
    i_compare_enable <= en;
    i_compare_below <= below;
    i_conversion_run <= 1'b1;
    k = 0;
    do
    begin
      @(negedge i_core_clk);
      k++;
    end
    while (!o_sar_start && k < 400);
    check(16'(k), 16'(4 + d_tab[c]));
    check(16'(o_channel), 16'(ch));
    for (int i = 0; i < nconv; i++)
    begin
      rng = xs(rng);
      v = rng[9:0];
      k = 0;
      hi = 0;
      do
      begin
        hi += int'(o_sample);
        @(posedge i_core_clk);
        if (k == 0)
          i_sar_value <= v;
        i_mode_write <= (mode == 2 && i == nconv - 1 && k == n_tab[c] - 2);
        if (mode == 1 && k == 50)
          i_conversion_run <= 1'b0;
        @(negedge i_core_clk);
        k++;
      end
      while (!o_end_strobe && o_busy && k < 400);
      if (mode == 1)
      begin
        check(16'(o_busy), 16'h0);
        check(16'(o_conversion_result), 16'(last));
        $display("test code %0d abort done", c);
        return;
      end
      check(16'(k), 16'(n_tab[c]));
      check(16'(hi), 16'(s_tab[c]));
      check(16'(o_sar_start), 16'h1);
      if (mode == 2 && i == nconv - 1)
        check(16'({o_result_valid, o_conversion_done_irq}), 16'h0);
      else
      begin
        last = v;
        check(16'(o_conversion_result), 16'(v));
        check(16'({1'b1, o_conversion_done_irq}), 16'({o_result_valid, !en || (below ? v < thr : v >= thr)}));
        check(16'(o_result_suspect), 16'(sus && i == 0));
      end
    end
    $display("test code %0d mode %0d done", c, mode);
  endtask

  task automatic stop_run();
    @(posedge i_core_clk);
    i_conversion_run <= 1'b0;
    repeat (3) @(negedge i_core_clk);
    check(16'(o_busy), 16'h0);
  endtask

  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  initial
  begin
    #500000;
    failures++;
    complete_run();
  end

  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    {i_resetn, i_conversion_run, i_reference_on, i_ref_high, i_mode_write} = '0;
    {i_channel_write, i_compare_enable, i_compare_below} = '0;
    {i_clk_en, i_sar_done} = 2'h3;
    {i_conversion_time_select, i_channel_select} = '0;
    {i_compare_threshold, i_sar_value, last} = '0;
    {failures, num_checks} = '0;
    rng = 32'hCF09;
    repeat (5) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    i_reference_on <= 1'b1;
    i_ref_high <= rng[0];
    repeat (40) @(posedge i_core_clk);
    for (int c = 0; c < 8; c++)
      if (n_tab[c] != 0)
      begin
        convs(c, 2, 0, 1'b0);
        stop_run();
      end
    for (int c = 3; c < 8; c += 4)
    begin
      @(posedge i_core_clk);
      i_conversion_time_select <= 3'(c);
      i_conversion_run <= 1'b1;
      repeat (30) @(negedge i_core_clk);
      check(16'({o_busy, o_code_bad}), 16'h1);
      stop_run();
      $display("test code %0d refused done", c);
    end
    @(posedge i_core_clk);
    i_reference_on <= 1'b0;
    convs(0, 2, 0, 1'b1);
    stop_run();
    @(posedge i_core_clk);
    i_reference_on <= 1'b1;
    // run set before the reference has settled: first result flagged
    convs(5, 2, 2, 1'b1);
    stop_run();
    convs(6, 1, 1, 1'b0);
    stop_run();
    complete_run();
  end
endmodule

bind adc_conversion_timing_control adc_timing_checker u_checker (
  .i_core_clk, .i_resetn, .i_conversion_run, .i_conversion_time_select, .i_mode_write,
  .i_channel_write, .i_compare_enable, .i_sar_done, .i_sar_value, .o_sample, .o_sar_start,
  .o_conversion_result, .o_result_valid, .o_conversion_done_irq, .o_end_strobe, .o_busy);
